// ===== design/ctf_defs.svh
// constants for the configurable timer family
`ifndef CTF_DEFS_SVH
`define CTF_DEFS_SVH
`define CTF_CNT_W        16
`define CTF_PSC_W        16
`define CTF_NUM_CH_GP    4
`define CTF_DT_W         8
`define CTF_CNT_RST      16'h0000
`define CTF_PSC_RST      16'h0000
`define CTF_ARR_RST      16'hffff
`define CTF_CCR_RST      16'h0000
`define CTF_DT_RST       8'h00
`define CTF_TRG_UPDATE   2'h0
`define CTF_TRG_CH0      2'h1
`define CTF_TRG_ENABLE   2'h2
`define CTF_TRG_RESET    2'h3
`endif

// ===== design/ctf_pkg.sv
// types for the configurable timer family
package ctf_pkg;
  // counting direction mode
  typedef enum logic [1:0] {
    CTF_CNT_UP     = 2'h0,
    CTF_CNT_DOWN   = 2'h1,
    CTF_CNT_CENTER = 2'h3
  } ctf_cnt_mode_t;

  // channel function
  typedef enum logic [2:0] {
    CTF_CH_OFF     = 3'h0,
    CTF_CH_CAPTURE = 3'h1,
    CTF_CH_COMPARE = 3'h3,
    CTF_CH_PWM     = 3'h2,
    CTF_CH_PULSE   = 3'h6
  } ctf_ch_mode_t;

  // slave behaviour on an incoming link trigger
  typedef enum logic [1:0] {
    CTF_SLV_OFF   = 2'h0,
    CTF_SLV_RESET = 2'h1,
    CTF_SLV_GATE  = 2'h3,
    CTF_SLV_START = 2'h2
  } ctf_slave_mode_t;

  // counter input source
  typedef enum logic [1:0] {
    CTF_SRC_CLK     = 2'h0,
    CTF_SRC_ENCODER = 2'h1,
    CTF_SRC_HALL    = 2'h3
  } ctf_src_t;

  typedef struct packed {
    logic            enable;
    ctf_cnt_mode_t   cnt_mode;
    ctf_src_t        src;
    ctf_slave_mode_t slave_mode;
    logic [1:0]      trg_sel;
    logic            dbg_freeze;
    logic            one_shot;
    logic [15:0]     prescale;
    logic [15:0]     reload;
    logic [7:0]      dead_time;
  } ctf_cfg_t;

  typedef struct packed {
    ctf_ch_mode_t mode;
    logic         polarity;
    logic         dma_en;
    logic [15:0]  compare;
  } ctf_ch_cfg_t;
endpackage

// ===== design/ctf_dead_time.sv
// complementary output pair with dead-time insertion
`timescale 1ns/1ps
`include "ctf_defs.svh"
module ctf_dead_time #(
  parameter int DT_W = `CTF_DT_W
) (
  input  wire logic            mclk,     // system clock
  input  wire logic            rst,      // synchronous reset
  input  wire logic            ref_in,   // reference pwm level
  input  wire logic [DT_W-1:0] dead,     // dead time in cycles
  input  wire logic            kill,     // force both outputs inactive
  output logic                 out_p,    // main output
  output logic                 out_n     // complementary output
);
  logic            ref_reg;
  logic [DT_W-1:0] dly_reg;

  // ===========================================
  // delay counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_reg <= 1'b0;
      dly_reg <= '0;
    end else if (ref_in != ref_reg) begin
      ref_reg <= ref_in;
      dly_reg <= dead;
    end else if (dly_reg != '0) begin
      dly_reg <= dly_reg - 1'b1;
    end
  end

  // ===========================================
  // outputs: each edge waits out the gap so the pair never overlaps
  always_ff @(posedge mclk) begin
    if (rst || kill) begin
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else if (ref_in != ref_reg && dead != '0) begin
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else if (dly_reg <= 1 || ref_in != ref_reg) begin
      out_p <= ref_in;
      out_n <= ~ref_in;
    end
  end
endmodule // ctf_dead_time

// ===== design/ctf_timer.sv
// one configurable timer of the family, variant chosen by parameter
`timescale 1ns/1ps
`include "ctf_defs.svh"
// Summary of operation
// - The four-channel variant counts a 16-bit auto-reload counter up, down or up/down from a 16-bit prescaler.
// - The four-channel variant has four channels, each capture, compare, PWM or single pulse.
// - The advanced variant drives complementary output pairs separated by a programmable dead time.
// - PWM on the advanced variant works in edge-aligned and centre-aligned counting.
// - The advanced variant reaches any duty from fully off to fully on.
// - The advanced variant also offers all capture, compare and counting features of the four-channel one.
// - During debug halt the advanced variant can freeze its counter and force its outputs inactive.
// - The four-channel variant can freeze its counter during debug halt.
// - Timers exchange trigger outputs and trigger inputs so one can start, reset, gate or chain another.
// - The four-channel variant decodes quadrature encoder inputs and one to three hall sensor inputs.
// - Each four-channel timer raises its own DMA requests.
// - Reduced variants count up only, have one or two channels, and no DMA request.
// - Reduced variants accept link triggers and also serve as a simple time base.
// - The basic variant has no channels and its update event is the converter trigger.
module ctf_timer #(
  parameter int  NUM_CH   = `CTF_NUM_CH_GP, // 0 basic, 1/2 reduced, 4 full
  parameter bit  ADVANCED = 1'b0,           // complementary outputs present
  parameter bit  UP_ONLY  = 1'b0,           // reduced variants count up only
  parameter bit  HAS_DMA  = 1'b1,           // dma request generation
  parameter int  CNT_W    = `CTF_CNT_W,     // counter width
  parameter int  PSC_W    = `CTF_PSC_W      // prescaler width
) (
  input  wire logic                   mclk,        // system clock
  input  wire logic                   rst,         // synchronous reset
  input  wire ctf_pkg::ctf_cfg_t      cfg,         // timer configuration
  input  wire ctf_pkg::ctf_ch_cfg_t   ch_cfg [4],  // channel configuration
  input  wire logic [3:0]             ch_in,       // capture inputs
  input  wire logic                   enc_a,       // encoder phase a
  input  wire logic                   enc_b,       // encoder phase b
  input  wire logic [2:0]             hall_in,     // hall sensor inputs
  input  wire logic [2:0]             hall_used,   // which hall inputs are fitted
  input  wire logic                   dbg_halt,    // processor halted in debug
  input  wire logic                   trg_in,      // link trigger from another timer
  output logic                        trg_out,     // link trigger to other timers
  output logic                        update,      // update event pulse
  output logic                        dac_trig,    // converter trigger pulse
  output logic [CNT_W-1:0]            count,       // current counter value
  output logic                        dir_down,    // counting down
  output logic [3:0]                  ch_out,      // channel output levels
  output logic [3:0]                  ch_out_n,    // complementary outputs
  output logic [15:0]                 capture [4], // captured values
  output logic [3:0]                  cap_evt,     // capture event pulses
  output logic [3:0]                  dma_req      // dma request pulses
);
  // refuse variants the logic below cannot build
  if (!(NUM_CH == 0 || NUM_CH == 1 || NUM_CH == 2 || NUM_CH == 4)) begin : g_bad_ch
    $error("ctf_timer: NUM_CH must be 0, 1, 2 or 4");
  end
  if (CNT_W != 16 || PSC_W != 16) begin : g_bad_w
    $error("ctf_timer: counter and prescaler are 16 bits");
  end
  if (ADVANCED && NUM_CH != 4) begin : g_bad_adv
    $error("ctf_timer: advanced variant needs four channels");
  end

  typedef enum logic [1:0] {
    CTF_ST_IDLE = 2'b00,
    CTF_ST_RUN  = 2'b01,
    CTF_ST_HOLD = 2'b11
  } ctf_state_t;

  ctf_state_t        state_reg;
  ctf_state_t        state_next;
  logic [PSC_W-1:0]  psc_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              down_reg;
  logic              tick;
  logic              frozen;
  logic              run;
  logic              wrap;
  logic              trg_d_reg;
  logic              trg_rise;
  logic [1:0]        enc_reg;
  logic [2:0]        hall_reg;
  logic              enc_step;
  logic              enc_dir_down;
  logic              hall_chg;
  logic              ev_src;
  ctf_pkg::ctf_cnt_mode_t mode_eff;

  // ===========================================
  // trigger and sensor edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      trg_d_reg <= 1'b0;
      enc_reg   <= 2'h0;
      hall_reg  <= 3'h0;
    end else begin
      trg_d_reg <= trg_in;
      enc_reg   <= {enc_a, enc_b};
      hall_reg  <= hall_in & hall_used;
    end
  end

  assign trg_rise = trg_in & ~trg_d_reg;
  // quadrature: a step on either phase edge, direction from phase order
  assign enc_step     = (enc_reg != {enc_a, enc_b});
  assign enc_dir_down = (enc_a ^ enc_reg[0]);
  assign hall_chg     = ((hall_in & hall_used) != hall_reg) && (hall_used != 3'h0);

  // debug freeze: every variant honours it, including reduced and basic
  assign frozen   = dbg_halt & cfg.dbg_freeze;
  assign mode_eff = UP_ONLY ? ctf_pkg::CTF_CNT_UP : cfg.cnt_mode;

  // ===========================================
  // run control and slave behaviour
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CTF_ST_IDLE: begin
        if (cfg.enable && cfg.slave_mode != ctf_pkg::CTF_SLV_START)
          state_next = CTF_ST_RUN;
        else if (cfg.enable && trg_rise)
          state_next = CTF_ST_RUN;
      end
      CTF_ST_RUN: begin
        if (!cfg.enable)
          state_next = CTF_ST_IDLE;
        else if (cfg.one_shot && wrap)
          state_next = CTF_ST_HOLD;
      end
      CTF_ST_HOLD: begin
        if (!cfg.enable)
          state_next = CTF_ST_IDLE;
      end
      default: state_next = CTF_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst)
      state_reg <= CTF_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // enable gates run at once so the disabling edge raises no stale update
  assign run = (state_reg == CTF_ST_RUN) && cfg.enable && !frozen &&
               !(cfg.slave_mode == ctf_pkg::CTF_SLV_GATE && !trg_in);

  // ===========================================
  // prescaler: divide by prescale+1, 1 to 65536
  always_ff @(posedge mclk) begin
    if (rst || !run)
      psc_reg <= `CTF_PSC_RST;
    else if (psc_reg >= cfg.prescale)
      psc_reg <= '0;
    else
      psc_reg <= psc_reg + 1'b1;
  end

  always_comb begin
    case (cfg.src)
      ctf_pkg::CTF_SRC_ENCODER: ev_src = enc_step && NUM_CH == 4;
      ctf_pkg::CTF_SRC_HALL:    ev_src = hall_chg && NUM_CH == 4;
      default:                  ev_src = (psc_reg >= cfg.prescale);
    endcase
  end
  assign tick = run && ev_src;

  // ===========================================
  // counter
  assign wrap = tick && cfg.src == ctf_pkg::CTF_SRC_CLK && (
                (mode_eff == ctf_pkg::CTF_CNT_UP   && cnt_reg >= cfg.reload) ||
                (mode_eff == ctf_pkg::CTF_CNT_DOWN && cnt_reg == '0) ||
                (mode_eff == ctf_pkg::CTF_CNT_CENTER &&
                 ((!down_reg && cnt_reg >= cfg.reload) || (down_reg && cnt_reg == '0))));

  always_ff @(posedge mclk) begin
    if (rst || !cfg.enable) begin
      cnt_reg  <= `CTF_CNT_RST;
      down_reg <= 1'b0;
    end else if (cfg.slave_mode == ctf_pkg::CTF_SLV_RESET && trg_rise) begin
      cnt_reg  <= '0;
      down_reg <= 1'b0;
    end else if (tick && cfg.src == ctf_pkg::CTF_SRC_ENCODER) begin
      cnt_reg  <= enc_dir_down ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
      down_reg <= enc_dir_down;
    end else if (tick && cfg.src == ctf_pkg::CTF_SRC_HALL) begin
      cnt_reg  <= cnt_reg + 1'b1;
    end else if (tick) begin
      case (mode_eff)
        ctf_pkg::CTF_CNT_DOWN: begin
          cnt_reg  <= wrap ? cfg.reload : cnt_reg - 1'b1;
          down_reg <= 1'b1;
        end
        ctf_pkg::CTF_CNT_CENTER: begin
          if (!down_reg) begin
            cnt_reg  <= wrap ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
            down_reg <= wrap;
          end else begin
            cnt_reg  <= wrap ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
            down_reg <= !wrap;
          end
        end
        default: begin
          cnt_reg  <= wrap ? '0 : cnt_reg + 1'b1;
          down_reg <= 1'b0;
        end
      endcase
    end
  end

  assign count    = cnt_reg;
  assign dir_down = down_reg;

  // ===========================================
  // update event, converter and link triggers
  always_ff @(posedge mclk) begin
    if (rst) begin
      update   <= 1'b0;
      dac_trig <= 1'b0;
      trg_out  <= 1'b0;
    end else begin
      update   <= wrap;
      dac_trig <= wrap && NUM_CH == 0;
      case (cfg.trg_sel)
        `CTF_TRG_CH0:    trg_out <= (NUM_CH != 0) && ch_out[0];
        `CTF_TRG_ENABLE: trg_out <= run;
        `CTF_TRG_RESET:  trg_out <= trg_rise;
        default:         trg_out <= wrap;
      endcase
    end
  end

  // ===========================================
  // channels
  logic [3:0] ref_lvl;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      if (g < NUM_CH) begin : g_on
        logic in_d_reg;
        logic pulse_done_reg;
        logic hit;
        logic cap_now;
        assign hit = (cnt_reg == ch_cfg[g].compare) && tick;
        // polarity chooses the capture edge
        assign cap_now = (ch_cfg[g].mode == ctf_pkg::CTF_CH_CAPTURE) &&
                         (ch_in[g] != in_d_reg) && (ch_in[g] ^ ch_cfg[g].polarity);

        always_ff @(posedge mclk) begin
          if (rst) begin
            in_d_reg       <= 1'b0;
            capture[g]     <= `CTF_CCR_RST;
            cap_evt[g]     <= 1'b0;
            dma_req[g]     <= 1'b0;
            pulse_done_reg <= 1'b0;
            ref_lvl[g]     <= 1'b0;
          end else begin
            in_d_reg   <= ch_in[g];
            cap_evt[g] <= cap_now;
            if (cap_now)
              capture[g] <= cnt_reg;
            dma_req[g] <= HAS_DMA && ch_cfg[g].dma_en && (cap_now || hit);
            if (wrap)
              pulse_done_reg <= 1'b1;
            else if (!cfg.enable)
              pulse_done_reg <= 1'b0;
            case (ch_cfg[g].mode)
              ctf_pkg::CTF_CH_COMPARE: if (hit) ref_lvl[g] <= ~ref_lvl[g];
              // compare 0 stays off, compare above reload stays on
              ctf_pkg::CTF_CH_PWM:
                ref_lvl[g] <= (cnt_reg < ch_cfg[g].compare);
              ctf_pkg::CTF_CH_PULSE:
                ref_lvl[g] <= !pulse_done_reg && (cnt_reg >= ch_cfg[g].compare) &&
                              (state_reg == CTF_ST_RUN);
              default: ref_lvl[g] <= 1'b0;
            endcase
          end
        end

        if (ADVANCED) begin : g_adv
          logic p_raw;
          logic n_raw;
          ctf_dead_time #(.DT_W(`CTF_DT_W)) u_dt (
            .mclk   (mclk),
            .rst    (rst),
            .ref_in (ref_lvl[g] ^ ch_cfg[g].polarity),
            .dead   (cfg.dead_time),
            .kill   (frozen || ch_cfg[g].mode == ctf_pkg::CTF_CH_OFF),
            .out_p  (p_raw),
            .out_n  (n_raw)
          );
          assign ch_out[g]   = p_raw;
          assign ch_out_n[g] = n_raw;
        end else begin : g_std
          assign ch_out[g]   = ref_lvl[g] ^ ch_cfg[g].polarity;
          assign ch_out_n[g] = 1'b0;
        end
      end else begin : g_off
        assign ref_lvl[g]  = 1'b0;
        assign ch_out[g]   = 1'b0;
        assign ch_out_n[g] = 1'b0;
        assign capture[g]  = '0;
        assign cap_evt[g]  = 1'b0;
        assign dma_req[g]  = 1'b0;
      end
    end
  endgenerate
endmodule // ctf_timer

// ===== tb/ctf_timer_monitor.sv
// concurrent checks on the ports of one configurable timer
`timescale 1ns/1ps
module ctf_timer_monitor #(
  parameter int NUM_CH = 4 // channel count of the watched timer
) (
  input wire logic              mclk,        // system clock
  input wire logic              rst,         // synchronous reset
  input wire ctf_pkg::ctf_cfg_t cfg,         // timer configuration
  input wire logic              dbg_halt,    // debug halt
  input wire logic              update,      // update pulse
  input wire logic              dac_trig,    // converter trigger
  input wire logic [15:0]       count,       // counter value
  input wire logic              dir_down,    // counting down
  input wire logic [3:0]        ch_out,      // channel outputs
  input wire logic [3:0]        ch_out_n,    // complementary outputs
  input wire logic [15:0]       capture [4], // captured values
  input wire logic [3:0]        cap_evt      // capture pulses
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // sequences
  sequence s_frozen;
    dbg_halt && cfg.dbg_freeze;
  endsequence
  // wrap from reload to zero while free running upward
  sequence s_wrap;
    cfg.enable && $past(cfg.enable) && cfg.cnt_mode == ctf_pkg::CTF_CNT_UP
      && cfg.src == ctf_pkg::CTF_SRC_CLK && cfg.slave_mode == ctf_pkg::CTF_SLV_OFF
      && cfg.reload != 16'h0000 && $past(count) == cfg.reload && count == 16'h0000;
  endsequence
  // ==========================================================
  // assertions
  a_update_single: assert property (update |=> !update)
    else $error("update pulse longer than one cycle");
  a_wrap_update: assert property (s_wrap |-> ##[0:1] update)
    else $error("reload without update event");
  a_freeze_hold: assert property (s_frozen ##0 cfg.enable |=> $stable(count))
    else $error("counter moved while frozen");
  a_freeze_kill: assert property (s_frozen [*3] |-> (ch_out | ch_out_n) == 4'h0)
    else $error("outputs active during debug halt");
  a_pair_exclusive: assert property ((ch_out & ch_out_n) == 4'h0)
    else $error("output and complement high together");
  a_dac_quiet: assert property (NUM_CH != 0 |-> !dac_trig)
    else $error("converter trigger from a channel timer");
  a_down_dir: assert property (((cfg.enable && cfg.cnt_mode == ctf_pkg::CTF_CNT_DOWN
    && cfg.src == ctf_pkg::CTF_SRC_CLK) [*3] ##0 count != 16'h0000) |-> dir_down)
    else $error("down mode not counting down");
  a_up_dir: assert property ((cfg.enable && cfg.cnt_mode == ctf_pkg::CTF_CNT_UP
    && cfg.src == ctf_pkg::CTF_SRC_CLK) [*3] |-> !dir_down)
    else $error("up mode counting down");
  a_capture_value: assert property (cap_evt[0] |-> capture[0] == $past(count))
    else $error("captured value differs from counter");
  a_idle_zero: assert property (!cfg.enable |=> count == 16'h0000)
    else $error("counter not cleared while disabled");
endmodule // ctf_timer_monitor

bind ctf_timer ctf_timer_monitor #(.NUM_CH(NUM_CH)) ctf_timer_monitor_i (
  .mclk(mclk), .rst(rst), .cfg(cfg), .dbg_halt(dbg_halt), .update(update),
  .dac_trig(dac_trig), .count(count), .dir_down(dir_down), .ch_out(ch_out),
  .ch_out_n(ch_out_n), .capture(capture), .cap_evt(cap_evt));

// ===== tb/ctf_timer_test.sv
// self-checking bench for the advanced four-channel timer variant
`timescale 1ns/1ps
module ctf_timer_test;
  logic                 mclk, rst, enc_a, enc_b, dbg_halt, trg_in;
  logic                 trg_out, update, dac_trig, dir_down;
  ctf_pkg::ctf_cfg_t    cfg;
  ctf_pkg::ctf_ch_cfg_t ch_cfg [4];
  logic [3:0]           ch_in, ch_out, ch_out_n, cap_evt, dma_req;
  logic [2:0]           hall_in, hall_used;
  logic [15:0]          count;
  logic [15:0]          capture [4];
  int                   n_fail, check_count, cyc;

  ctf_timer #(.NUM_CH(4), .ADVANCED(1'b1), .UP_ONLY(1'b0), .HAS_DMA(1'b1)) ctf_timer_i (
    .mclk(mclk), .rst(rst), .cfg(cfg), .ch_cfg(ch_cfg), .ch_in(ch_in), .enc_a(enc_a),
    .enc_b(enc_b), .hall_in(hall_in), .hall_used(hall_used), .dbg_halt(dbg_halt),
    .trg_in(trg_in), .trg_out(trg_out), .update(update), .dac_trig(dac_trig),
    .count(count), .dir_down(dir_down), .ch_out(ch_out), .ch_out_n(ch_out_n),
    .capture(capture), .cap_evt(cap_evt), .dma_req(dma_req));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // helpers
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  // disable first so the new setting starts from a cleared counter
  task automatic restart(ctf_pkg::ctf_cfg_t c);
    @(posedge mclk);
    cfg.enable <= 1'b0;
    @(posedge mclk);
    cfg <= c;
  endtask
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (update !== 1'b1 && n < 3000);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_period;
    ctf_pkg::ctf_cnt_mode_t md [3] = '{ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_CNT_UP,
                                       ctf_pkg::CTF_CNT_DOWN};
    logic [15:0] ps [3] = '{16'h0000, 16'h0002, 16'h0001};
    logic [15:0] rl [3] = '{16'h0002, 16'h0003, 16'h0004};
    int n;
    logic up_seen, dn_seen;
    for (int i = 0; i < 3; i++) begin
      restart('{1'b1, md[i], ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_OFF, 2'h0, 1'b0,
                1'b0, ps[i], rl[i], 8'h02});
      wait_upd(n);
      wait_upd(n);
      check("period", n[15:0], 16'((ps[i] + 1) * (rl[i] + 1)));
      check("direction", {15'h0, dir_down}, {15'h0, i == 2});
    end
    restart('{1'b1, ctf_pkg::CTF_CNT_CENTER, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_OFF,
              2'h0, 1'b0, 1'b0, 16'h0000, 16'h0004, 8'h02});
    up_seen = 1'b0;
    dn_seen = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      up_seen |= (dir_down === 1'b0);
      dn_seen |= (dir_down === 1'b1);
    end
    check("center turns", {14'h0, up_seen, dn_seen}, 16'h0003);
    $display("done period");
  endtask
  task automatic t_pwm;
    logic [15:0] cmp [3] = '{16'h0004, 16'h0000, 16'h000a};
    logic [15:0] ep [3] = '{16'h0002, 16'h0000, 16'h000a};
    logic [15:0] en [3] = '{16'h0004, 16'h000a, 16'h0000};
    int hp, hn;
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_OFF, 2'h0,
              1'b0, 1'b0, 16'h0000, 16'h0009, 8'h02});
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      ch_cfg[0] <= '{ctf_pkg::CTF_CH_PWM, 1'b0, 1'b0, cmp[i]};
      tick(30);
      hp = 0;
      hn = 0;
      repeat (10) begin
        @(posedge mclk);
        hp += int'(ch_out[0] === 1'b1);
        hn += int'(ch_out_n[0] === 1'b1);
      end
      check("main high", hp[15:0], ep[i]);
      check("complement high", hn[15:0], en[i]);
    end
    $display("done pwm");
  endtask
  // pwm still fully on, so a forced-off output is visible
  task automatic t_freeze;
    @(posedge mclk);
    dbg_halt <= 1'b1;
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_OFF, 2'h0,
              1'b1, 1'b0, 16'h0000, 16'h0009, 8'h02});
    tick(10);
    check("frozen count", count, 16'h0000);
    check("killed outputs", {8'h0, ch_out, ch_out_n}, 16'h0000);
    dbg_halt <= 1'b0;
    tick(5);
    check("resumed", {15'h0, count != 16'h0000}, 16'h0001);
    $display("done freeze");
  endtask
  task automatic t_capture;
    logic ce, dr;
    @(posedge mclk);
    ch_cfg[0] <= '{ctf_pkg::CTF_CH_CAPTURE, 1'b0, 1'b1, 16'h0000};
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_OFF, 2'h0,
              1'b0, 1'b0, 16'h0000, 16'h0002, 8'h02});
    tick(5);
    ch_in[0] <= 1'b1;
    ce = 1'b0;
    dr = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      ce |= (cap_evt[0] === 1'b1);
      dr |= (dma_req[0] === 1'b1);
    end
    check("capture event", {15'h0, ce}, 16'h0001);
    check("dma request", {15'h0, dr}, 16'h0001);
    check("capture range", {15'h0, capture[0] <= 16'h0002}, 16'h0001);
    $display("done capture");
  endtask
  task automatic t_link;
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_START,
              2'h2, 1'b0, 1'b0, 16'h0000, 16'h0009, 8'h02});
    tick(5);
    check("waiting count", count, 16'h0000);
    check("idle link out", {15'h0, trg_out}, 16'h0000);
    trg_in <= 1'b1;
    tick(5);
    check("started", {15'h0, count != 16'h0000}, 16'h0001);
    check("running link out", {15'h0, trg_out}, 16'h0001);
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_GATE,
              2'h0, 1'b0, 1'b0, 16'h0000, 16'h00ff, 8'h02});
    trg_in <= 1'b0;
    tick(5);
    check("gated count", count, 16'h0000);
    trg_in <= 1'b1;
    tick(5);
    check("gate open", {15'h0, count != 16'h0000}, 16'h0001);
    $display("done link");
  endtask
  // one-shot run: a single pulse on channel 0, one compare toggle on channel 1
  task automatic t_shot;
    int hp, nu;
    @(posedge mclk);
    ch_cfg[0] <= '{ctf_pkg::CTF_CH_PULSE, 1'b0, 1'b0, 16'h0002};
    ch_cfg[1] <= '{ctf_pkg::CTF_CH_COMPARE, 1'b0, 1'b0, 16'h0003};
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_CLK, ctf_pkg::CTF_SLV_OFF, 2'h0,
              1'b0, 1'b1, 16'h0000, 16'h0005, 8'h00});
    hp = 0;
    nu = 0;
    repeat (30) begin
      @(posedge mclk);
      hp += int'(ch_out[0] === 1'b1);
      nu += int'(update === 1'b1);
    end
    check("pulse width", hp[15:0], 16'h0004);
    check("single update", nu[15:0], 16'h0001);
    check("compare toggle", {14'h0, ch_out[1], ch_out_n[1]}, 16'h0002);
    $display("done one shot");
  endtask
  // a full quadrature cycle forward then back must return to zero
  task automatic t_sensor;
    logic [1:0] ph [8] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01, 2'b11, 2'b10, 2'b00};
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_ENCODER, ctf_pkg::CTF_SLV_OFF,
              2'h0, 1'b0, 1'b0, 16'h0000, 16'hffff, 8'h02});
    for (int i = 0; i < 8; i++) begin
      tick(3);
      {enc_a, enc_b} <= ph[i];
      if (i == 4)
        check("four edges", {15'h0, count == 16'h0004 || count == 16'hfffc}, 16'h0001);
    end
    tick(4);
    check("encoder back", count, 16'h0000);
    restart('{1'b1, ctf_pkg::CTF_CNT_UP, ctf_pkg::CTF_SRC_HALL, ctf_pkg::CTF_SLV_OFF, 2'h0,
              1'b0, 1'b0, 16'h0000, 16'hffff, 8'h02});
    hall_used <= 3'b001;
    tick(3);
    hall_in <= 3'b100;
    tick(4);
    check("unfitted hall", count, 16'h0000);
    hall_in <= 3'b101;
    tick(4);
    check("fitted hall", {15'h0, count != 16'h0000}, 16'h0001);
    $display("done sensor");
  endtask
  // ==========================================================
  // main sequence and hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {rst, enc_a, enc_b, dbg_halt, trg_in} = 5'b10000;
    cfg = '0;
    ch_cfg = '{default: '0};
    {ch_in, hall_in, hall_used} = '0;
    {n_fail, check_count, cyc} = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    tick(2);
    check("reset count", count, 16'h0000);
    check("reset outputs", {7'h0, update, ch_out, ch_out_n}, 16'h0000);
    t_period();
    t_pwm();
    t_freeze();
    t_capture();
    t_link();
    t_sensor();
    t_shot();
    end_sim();
  end
endmodule // ctf_timer_test
